// ### hw/pgp_pkg.sv
// Constants shared by the packet driven pin port and its input sampler.
// Assumes a single 250 MHz clock and byte wide packet fields.
package pgp_pkg;
   localparam int NPIN = 13;
   localparam int NHDR = 5;
   localparam int NLED = 8;
   localparam logic [7:0] NPIN_IDX = 8'h0d;

   // Packet types of requests and of their replies.
   localparam logic [7:0] TYPE_SET = 8'h22;
   localparam logic [7:0] TYPE_GET = 8'h23;
   localparam logic [7:0] RSP_SET = 8'h62;
   localparam logic [7:0] RSP_GET = 8'h63;
   localparam logic [7:0] RSP_NONE = 8'h00;
   localparam logic [1:0] LEN_GET = 2'h1;
   localparam logic [1:0] LEN_VAL = 2'h2;
   localparam logic [1:0] LEN_CFG = 2'h3;
   localparam logic [2:0] RLEN_GET = 3'h4;

   // Timing.
   localparam int CLK_PERIOD_NS = 4;
   localparam int PWM_PERIOD_NS = 10_000_000;
   localparam int SAMPLE_PERIOD_NS = 20_000_000;
   localparam int PWM_STEPS = 100;
   localparam int PWM_STEP_CYC = PWM_PERIOD_NS / PWM_STEPS / CLK_PERIOD_NS;
   localparam int SAMPLE_CYC = SAMPLE_PERIOD_NS / CLK_PERIOD_NS;
   localparam logic [6:0] PCT_LAST = 7'h63;

   // Configuration byte fields.
   localparam int CFG_W = 4;
   localparam int CFG_FUNC = 3;
   localparam logic [2:0] DM_UP_PD = 3'h0;
   localparam logic [2:0] DM_STRONG = 3'h1;
   localparam logic [2:0] DM_INPUT = 3'h2;
   localparam logic [2:0] DM_PU_DOWN = 3'h3;
   localparam logic [2:0] DM_SLOW_UP = 3'h4;
   localparam logic [2:0] DM_SLOW = 3'h5;
   localparam logic [2:0] DM_RSVD = 3'h6;
   localparam logic [2:0] DM_SLOW_DN = 3'h7;

   // Status byte fields.
   localparam int STAT_LVL = 0;
   localparam int STAT_FALL = 1;
   localparam int STAT_RISE = 2;

   // Reset values.
   localparam logic [7:0] RST_DUTY = 8'h00;
   localparam logic [3:0] RST_CFG = 4'h0;

   // Register byte offsets on the AXI4-Lite bus.
   localparam int ADDR_W = 8;
   localparam logic [7:0] ADDR_REQ_DATA = 8'h00;
   localparam logic [7:0] ADDR_REQ_CTRL = 8'h04;
   localparam logic [7:0] ADDR_RSP_HDR = 8'h08;
   localparam logic [7:0] ADDR_RSP_DATA = 8'h0c;
   localparam logic [7:0] ADDR_BOOT = 8'h10;
   localparam int BOOT_STORE = 0;
   localparam int BOOT_LOAD = 1;
   localparam int RSP_ERR_BIT = 16;

   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_DECERR = 2'h3;
endpackage

// ### hw/pgp_smp_if.sv
// Carries the sampling tick, raw levels, query clears and sampled results.
// Assumes both ends run on the same clock.
interface pgp_smp_if;
   logic tick;
   logic [pgp_pkg::NPIN-1:0] raw;
   logic [pgp_pkg::NPIN-1:0] clr;
   logic [pgp_pkg::NPIN-1:0] level;
   logic [pgp_pkg::NPIN-1:0] rise;
   logic [pgp_pkg::NPIN-1:0] fall;
   modport ctl(output tick, raw, clr, input level, rise, fall);
   modport smp(input tick, raw, clr, output level, rise, fall);
endinterface

// ### hw/pgp_sampler.sv
// Periodic pin sampler with debounced level and sticky edge flags.
// Assumes raw levels are already synchronous and tick is a one cycle pulse.
module pgp_sampler (
   input wire logic clk,
   input wire logic rst,
   pgp_smp_if.smp s
);
   logic [pgp_pkg::NPIN-1:0] prev_r, prev_nxt;
   logic [pgp_pkg::NPIN-1:0] level_r, level_nxt;
   logic [pgp_pkg::NPIN-1:0] rise_r, rise_nxt;
   logic [pgp_pkg::NPIN-1:0] fall_r, fall_nxt;
   logic [pgp_pkg::NPIN-1:0] agree, rise_set, fall_set;

   // A level is accepted only when two successive samples agree, so
   // chatter shorter than one sample period never shows as a change.
   always_comb begin
      prev_nxt = prev_r;
      level_nxt = level_r;
      agree = ~(s.raw ^ prev_r);
      rise_set = '0;
      fall_set = '0;
      if (s.tick) begin
         prev_nxt = s.raw; // RL2
         level_nxt = (level_r & ~agree) | (s.raw & agree); // RL19
         rise_set = agree & s.raw & ~level_r; // RL21
         fall_set = agree & ~s.raw & level_r; // RL21
      end
      // A new edge in the clearing cycle survives the clear.
      rise_nxt = (rise_r & ~s.clr) | rise_set; // RL3
      fall_nxt = (fall_r & ~s.clr) | fall_set; // RL3
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         prev_r <= '0;
         level_r <= '0;
         rise_r <= '0;
         fall_r <= '0;
      end else begin
         prev_r <= prev_nxt;
         level_r <= level_nxt;
         rise_r <= rise_nxt;
         fall_r <= fall_nxt;
      end
   end

   assign s.level = level_r;
   assign s.rise = rise_r;
   assign s.fall = fall_r;
endmodule

// ### hw/pgp_port.sv
// Packet driven pin port: thirteen pins with level or PWM output, drive
// modes, periodic input sampling and edge flags, reached over AXI4-Lite.
// Assumes software writes request fields, then the control word, and reads
// the reply registers; default pin functions arrive on dflt_out/dflt_oe.
//
// Operation
// (RL1) Duty 0 low, 100 high, else 100 Hz PWM.
// (RL2) Sample every pin at 50 Hz.
// (RL3) Sticky edge flags clear when query answered.
// (RL4) Report sampled pin level, not commanded value.
// (RL5) Two bytes set value; three also set config.
// (RL6) Index 0-4 header, 5-12 LEDs, above ignored.
// (RL7) Host keeps output value within 0 to 100.
// (RL8) Value acts only with function set, output mode.
// (RL9) Config byte: mode bits 2-0, function bit 3.
// (RL10) Drive mode codes select high and low drive.
// (RL11) Host never programs reserved drive mode 110.
// (RL12) Function 0 default use, 1 host control.
// (RL13) Set is type 0x22, read is 0x23.
// (RL14) Read reply: index, status, value, config.
// (RL15) Status: level bit0, falling bit1, rising bit2.
// (RL16) Reserved config bits read back as zero.
// (RL17) Replies are 0x62 empty and 0x63.
// (RL18) Pin config saved as and restored from boot.
// (RL19) Input sampling ignores contact bounce.
// (RL20) Function 0 ignores stored duty and mode.
// (RL21) Edges found by comparing successive samples.
// (RL22) PWM period divided from clock, 1% steps.
//
// Local design decisions: the AXI4-Lite register port and the register offsets.
module pgp_port #(
   parameter int STEP_CYC = pgp_pkg::PWM_STEP_CYC,
   parameter int SAMPLE_CYC = pgp_pkg::SAMPLE_CYC
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic [pgp_pkg::NHDR-1:0] pad_in,
   input wire logic [pgp_pkg::NHDR-1:0] dflt_out,
   input wire logic [pgp_pkg::NHDR-1:0] dflt_oe,
   output logic [pgp_pkg::NHDR-1:0] pad_out,
   output logic [pgp_pkg::NHDR-1:0] pad_oe,
   output logic [pgp_pkg::NHDR-1:0] pad_pu,
   output logic [pgp_pkg::NHDR-1:0] pad_pd,
   output logic [pgp_pkg::NHDR-1:0] pad_slow,
   output logic [pgp_pkg::NLED-1:0] led_on
);
   localparam int STEP_W = $clog2(STEP_CYC + 1);
   localparam int SMP_W = $clog2(SAMPLE_CYC + 1);
   localparam int N = pgp_pkg::NPIN;

   // Index check shared by both request types.
   function automatic logic idx_ok(input logic [7:0] idx);
      idx_ok = idx < pgp_pkg::NPIN_IDX; // RL6
   endfunction

   // Drive decode: {out, oe, pull up, pull down, slow} for level v.
   function automatic logic [4:0] drive(input logic [2:0] m, input logic v);
      unique case (m) // RL10
         pgp_pkg::DM_UP_PD: drive = v ? 5'b11000 : 5'b00010;
         pgp_pkg::DM_STRONG: drive = {v, 4'b1000};
         pgp_pkg::DM_PU_DOWN: drive = v ? 5'b10100 : 5'b01000;
         pgp_pkg::DM_SLOW_UP: drive = v ? 5'b11001 : 5'b00000;
         pgp_pkg::DM_SLOW: drive = {v, 4'b1001};
         pgp_pkg::DM_SLOW_DN: drive = v ? 5'b00000 : 5'b01001;
         // Input mode and the reserved code leave the pin floating.
         default: drive = 5'b00000; // RL8
      endcase
   endfunction

   pgp_smp_if smp ();
   pgp_sampler u_sampler (.clk(clk), .rst(rst), .s(smp));

   // Timebase: PWM step, percent position and sampling tick.
   logic [STEP_W-1:0] step_r, step_nxt;
   logic [6:0] pct_r, pct_nxt;
   logic [SMP_W-1:0] scnt_r, scnt_nxt;
   logic tick_r, tick_nxt;

   always_comb begin
      step_nxt = step_r + STEP_W'(1);
      pct_nxt = pct_r;
      if (step_r == STEP_W'(STEP_CYC - 1)) begin // RL22
         step_nxt = '0;
         pct_nxt = (pct_r == pgp_pkg::PCT_LAST) ? 7'h00 : pct_r + 7'h01;
      end
      tick_nxt = scnt_r == SMP_W'(SAMPLE_CYC - 1); // RL2
      scnt_nxt = tick_nxt ? '0 : scnt_r + SMP_W'(1);
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         step_r <= '0;
         pct_r <= '0;
         scnt_r <= '0;
         tick_r <= 1'b0;
      end else begin
         step_r <= step_nxt;
         pct_r <= pct_nxt;
         scnt_r <= scnt_nxt;
         tick_r <= tick_nxt;
      end
   end

   // Bus, request and per pin settings.
   logic aw_v_r, aw_v_nxt, w_v_r, w_v_nxt;
   logic [7:0] awaddr_r, awaddr_nxt;
   logic [31:0] wdata_r, wdata_nxt;
   logic [3:0] wstrb_r, wstrb_nxt;
   logic bvalid_r, bvalid_nxt, rvalid_r, rvalid_nxt;
   logic [1:0] bresp_r, bresp_nxt, rresp_r, rresp_nxt;
   logic [31:0] rdata_r, rdata_nxt;
   logic [23:0] req_r, req_nxt;
   logic [7:0] rsp_type_r, rsp_type_nxt;
   logic [2:0] rsp_len_r, rsp_len_nxt;
   logic rsp_err_r, rsp_err_nxt;
   logic [31:0] rsp_data_r, rsp_data_nxt;
   logic [7:0] duty_r [N], duty_nxt [N], boot_duty_r [N], boot_duty_nxt [N];
   logic [3:0] cfg_r [N], cfg_nxt [N], boot_cfg_r [N], boot_cfg_nxt [N];
   logic [N-1:0] clr;
   logic do_wr, exec, hit;
   logic [7:0] idx, val, typ;
   logic [1:0] len;
   logic [3:0] sel;
   logic [7:0] stat;

   always_comb begin
      aw_v_nxt = aw_v_r;
      awaddr_nxt = awaddr_r;
      w_v_nxt = w_v_r;
      wdata_nxt = wdata_r;
      wstrb_nxt = wstrb_r;
      bvalid_nxt = bvalid_r;
      bresp_nxt = bresp_r;
      rvalid_nxt = rvalid_r;
      rresp_nxt = rresp_r;
      rdata_nxt = rdata_r;
      req_nxt = req_r;
      rsp_type_nxt = rsp_type_r;
      rsp_len_nxt = rsp_len_r;
      rsp_err_nxt = rsp_err_r;
      rsp_data_nxt = rsp_data_r;
      duty_nxt = duty_r;
      cfg_nxt = cfg_r;
      boot_duty_nxt = boot_duty_r;
      boot_cfg_nxt = boot_cfg_r;
      clr = '0;
      idx = req_r[7:0];
      val = req_r[15:8];
      sel = idx[3:0];
      typ = wdata_r[7:0];
      len = wdata_r[9:8];
      stat = 8'h00;
      if (s_axi_awvalid && !aw_v_r) begin
         aw_v_nxt = 1'b1;
         awaddr_nxt = s_axi_awaddr;
      end
      if (s_axi_wvalid && !w_v_r) begin
         w_v_nxt = 1'b1;
         wdata_nxt = s_axi_wdata;
         wstrb_nxt = s_axi_wstrb;
      end
      do_wr = aw_v_r && w_v_r && !bvalid_r;
      hit = awaddr_r == pgp_pkg::ADDR_REQ_DATA
         || awaddr_r == pgp_pkg::ADDR_REQ_CTRL
         || awaddr_r == pgp_pkg::ADDR_BOOT;
      exec = do_wr && awaddr_r == pgp_pkg::ADDR_REQ_CTRL
         && wstrb_r[1:0] == 2'b11;
      if (do_wr) begin
         aw_v_nxt = 1'b0;
         w_v_nxt = 1'b0;
         bvalid_nxt = 1'b1;
         bresp_nxt = hit ? pgp_pkg::RESP_OKAY : pgp_pkg::RESP_DECERR;
         if (awaddr_r == pgp_pkg::ADDR_REQ_DATA) begin
            for (int b = 0; b < 3; b++) begin
               if (wstrb_r[b]) begin
                  req_nxt[b*8 +: 8] = wdata_r[b*8 +: 8];
               end
            end
         end
         if (awaddr_r == pgp_pkg::ADDR_BOOT && wstrb_r[0]) begin
            if (wdata_r[pgp_pkg::BOOT_STORE]) begin
               boot_duty_nxt = duty_r; // RL18
               boot_cfg_nxt = cfg_r; // RL18
            end
            if (wdata_r[pgp_pkg::BOOT_LOAD]) begin
               duty_nxt = boot_duty_r; // RL18
               cfg_nxt = boot_cfg_r; // RL18
            end
         end
      end
      if (bvalid_r && s_axi_bready) begin
         bvalid_nxt = 1'b0;
      end
      if (exec) begin
         rsp_type_nxt = pgp_pkg::RSP_NONE;
         rsp_len_nxt = 3'h0;
         rsp_err_nxt = 1'b1;
         if (typ == pgp_pkg::TYPE_SET && idx_ok(idx) // RL13
             && (len == pgp_pkg::LEN_VAL || len == pgp_pkg::LEN_CFG)) begin
            duty_nxt[sel] = val; // RL5
            if (len == pgp_pkg::LEN_CFG) begin
               cfg_nxt[sel] = req_r[19:16]; // RL9
            end
            rsp_type_nxt = pgp_pkg::RSP_SET; // RL17
            rsp_err_nxt = 1'b0;
         end
         if (typ == pgp_pkg::TYPE_GET && idx_ok(idx)
             && len == pgp_pkg::LEN_GET) begin
            stat[pgp_pkg::STAT_LVL] = smp.level[sel]; // RL4
            stat[pgp_pkg::STAT_FALL] = smp.fall[sel]; // RL15
            stat[pgp_pkg::STAT_RISE] = smp.rise[sel]; // RL15
            rsp_data_nxt = {4'h0, cfg_r[sel], duty_r[sel], stat, // RL16
               idx}; // RL14
            rsp_type_nxt = pgp_pkg::RSP_GET; // RL17
            rsp_len_nxt = pgp_pkg::RLEN_GET;
            rsp_err_nxt = 1'b0;
            clr[sel] = 1'b1; // RL3
         end
      end
      if (s_axi_arvalid && !rvalid_r) begin
         rvalid_nxt = 1'b1;
         rresp_nxt = pgp_pkg::RESP_OKAY;
         unique case (s_axi_araddr)
            pgp_pkg::ADDR_REQ_DATA: rdata_nxt = {8'h00, req_r};
            pgp_pkg::ADDR_REQ_CTRL: rdata_nxt = 32'h0000_0000;
            pgp_pkg::ADDR_RSP_HDR: begin
               rdata_nxt = 32'h0000_0000;
               rdata_nxt[7:0] = rsp_type_r;
               rdata_nxt[10:8] = rsp_len_r;
               rdata_nxt[pgp_pkg::RSP_ERR_BIT] = rsp_err_r;
            end
            pgp_pkg::ADDR_RSP_DATA: rdata_nxt = rsp_data_r;
            pgp_pkg::ADDR_BOOT: rdata_nxt = 32'h0000_0000;
            default: begin
               rdata_nxt = 32'h0000_0000;
               rresp_nxt = pgp_pkg::RESP_DECERR;
            end
         endcase
      end else if (rvalid_r && s_axi_rready) begin
         rvalid_nxt = 1'b0;
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         aw_v_r <= 1'b0;
         awaddr_r <= '0;
         w_v_r <= 1'b0;
         wdata_r <= '0;
         wstrb_r <= '0;
         bvalid_r <= 1'b0;
         bresp_r <= pgp_pkg::RESP_OKAY;
         rvalid_r <= 1'b0;
         rresp_r <= pgp_pkg::RESP_OKAY;
         rdata_r <= '0;
         req_r <= '0;
         rsp_type_r <= pgp_pkg::RSP_NONE;
         rsp_len_r <= 3'h0;
         rsp_err_r <= 1'b0;
         rsp_data_r <= '0;
         for (int i = 0; i < N; i++) begin
            duty_r[i] <= pgp_pkg::RST_DUTY;
            cfg_r[i] <= pgp_pkg::RST_CFG;
            boot_duty_r[i] <= pgp_pkg::RST_DUTY;
            boot_cfg_r[i] <= pgp_pkg::RST_CFG;
         end
      end else begin
         aw_v_r <= aw_v_nxt;
         awaddr_r <= awaddr_nxt;
         w_v_r <= w_v_nxt;
         wdata_r <= wdata_nxt;
         wstrb_r <= wstrb_nxt;
         bvalid_r <= bvalid_nxt;
         bresp_r <= bresp_nxt;
         rvalid_r <= rvalid_nxt;
         rresp_r <= rresp_nxt;
         rdata_r <= rdata_nxt;
         req_r <= req_nxt;
         rsp_type_r <= rsp_type_nxt;
         rsp_len_r <= rsp_len_nxt;
         rsp_err_r <= rsp_err_nxt;
         rsp_data_r <= rsp_data_nxt;
         duty_r <= duty_nxt;
         cfg_r <= cfg_nxt;
         boot_duty_r <= boot_duty_nxt;
         boot_cfg_r <= boot_cfg_nxt;
      end
   end

   assign s_axi_awready = !aw_v_r;
   assign s_axi_wready = !w_v_r;
   assign s_axi_bvalid = bvalid_r;
   assign s_axi_bresp = bresp_r;
   assign s_axi_arready = !rvalid_r;
   assign s_axi_rvalid = rvalid_r;
   assign s_axi_rresp = rresp_r;
   assign s_axi_rdata = rdata_r;

   // Pin drive, registered; header inputs pass two flip-flops.
   logic [4:0] drv [N];
   logic [N-1:0] pwm;
   logic [pgp_pkg::NHDR-1:0] out_nxt, oe_nxt, pu_nxt, pd_nxt, slow_nxt;
   logic [pgp_pkg::NLED-1:0] led_nxt;
   logic [pgp_pkg::NHDR-1:0] sync1_r, sync2_r;

   generate
      for (genvar i = 0; i < N; i++) begin : g_pin
         assign pwm[i] = duty_r[i] > {1'b0, pct_r}; // RL1
         assign drv[i] = drive(cfg_r[i][2:0], pwm[i]);
      end
   endgenerate

   always_comb begin
      for (int i = 0; i < pgp_pkg::NHDR; i++) begin
         if (cfg_r[i][pgp_pkg::CFG_FUNC]) begin // RL12
            {out_nxt[i], oe_nxt[i], pu_nxt[i], pd_nxt[i], slow_nxt[i]} =
               drv[i]; // RL8
         end else begin
            out_nxt[i] = dflt_out[i]; // RL20
            oe_nxt[i] = dflt_oe[i]; // RL20
            pu_nxt[i] = 1'b0;
            pd_nxt[i] = 1'b0;
            slow_nxt[i] = 1'b0;
         end
      end
      for (int i = 0; i < pgp_pkg::NLED; i++) begin
         led_nxt[i] = cfg_r[i+pgp_pkg::NHDR][pgp_pkg::CFG_FUNC]
            && drv[i+pgp_pkg::NHDR][4] && drv[i+pgp_pkg::NHDR][3]; // RL6
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         pad_out <= '0;
         pad_oe <= '0;
         pad_pu <= '0;
         pad_pd <= '0;
         pad_slow <= '0;
         led_on <= '0;
         sync1_r <= '0;
         sync2_r <= '0;
      end else begin
         pad_out <= out_nxt;
         pad_oe <= oe_nxt;
         pad_pu <= pu_nxt;
         pad_pd <= pd_nxt;
         pad_slow <= slow_nxt;
         led_on <= led_nxt;
         sync1_r <= pad_in;
         sync2_r <= sync1_r;
      end
   end

   assign smp.tick = tick_r;
   assign smp.raw = {led_on, sync2_r}; // RL4
   assign smp.clr = clr;
endmodule

// ### verif/pgp_pad_model.sv
// Load on the header pins: one switch per pin plus the pad's own drive.
// Assumes the port drives its pad outputs from the same clock.
module pgp_pad_model (
   input wire logic clk,
   input wire logic [4:0] pad_out,
   input wire logic [4:0] pad_oe,
   input wire logic [4:0] pad_pu,
   input wire logic [4:0] pad_pd,
   input wire logic [4:0] ext_en,
   input wire logic [4:0] ext_val,
   output logic [4:0] pad_in
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [4:0] last;
   always_ff @(posedge clk) begin
      last <= pad_in;
   end
   // A pin nobody drives or pulls shows a changing level, never a hold.
   always_comb begin
      for (int i = 0; i < 5; i++) begin
         pad_in[i] = pad_oe[i] ? pad_out[i] : ext_en[i] ? ext_val[i] :
            pad_pu[i] ? 1'b1 : pad_pd[i] ? 1'b0 : ~last[i];
      end
   end
endmodule

// ### verif/pgp_port_assertions.sv
// Bus handshake and pad drive checks on the pin port's top ports.
// Assumes one clock and an asynchronous active high reset.
module pgp_port_assertions (
   input wire logic clk,
   input wire logic rst,
   input wire logic s_axi_awvalid,
   input wire logic s_axi_awready,
   input wire logic s_axi_wvalid,
   input wire logic s_axi_wready,
   input wire logic [1:0] s_axi_bresp,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic [4:0] pad_oe,
   input wire logic [4:0] pad_pu,
   input wire logic [4:0] pad_pd
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);
   sequence wr_tk;
      s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
   endsequence
   sequence rd_tk;
      s_axi_arvalid && s_axi_arready;
   endsequence
   wr_answer_a: assert property (wr_tk |=> ##1 s_axi_bvalid)
      else $error("write response missing");
   wr_refuse_a: assert property (wr_tk |=>
      !s_axi_awready && !s_axi_wready)
      else $error("write taken while earlier one held");
   b_stand_a: assert property (s_axi_bvalid && !s_axi_bready |=>
      s_axi_bvalid && $stable(s_axi_bresp))
      else $error("write response dropped");
   b_done_a: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
      else $error("write response repeated");
   rd_answer_a: assert property (rd_tk |=> s_axi_rvalid)
      else $error("read data missing");
   rd_refuse_a: assert property (s_axi_rvalid |-> !s_axi_arready)
      else $error("read taken while data pending");
   r_stand_a: assert property (s_axi_rvalid && !s_axi_rready |=>
      s_axi_rvalid && $stable(s_axi_rdata))
      else $error("read data dropped");
   pull_excl_a: assert property ((pad_pu & pad_pd) == 5'h00)
      else $error("pull up and down together");
   drive_pull_a: assert property ((pad_oe & (pad_pu | pad_pd)) == 5'h00)
      else $error("pull active while driving");
endmodule
bind pgp_port pgp_port_assertions i_chk (.clk, .rst, .s_axi_awvalid,
   .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
   .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
   .s_axi_rvalid, .s_axi_rready, .pad_oe, .pad_pu, .pad_pd);

// ### verif/pgp_port_tb.sv
// Self-checking bench for the pin port, acting as bus master and pin load.
// Assumes short PWM step and sample counts set through the parameters.
module pgp_port_tb;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int STEP = 4;
   localparam int SMP = 16;
   logic clk, rst, awv, awr, wv, wrd, bv, br, arv, arr, rv, rr;
   logic [7:0] awa, ara, led;
   logic [31:0] wd, rd_d, hdr, dat;
   logic [3:0] ws;
   logic [1:0] bresp, rresp, rsp;
   logic [4:0] pin, dout, doe, po, poe, ppu, ppd, psl, ext_val;
   int fail_count, check_count, i, d, n;

   pgp_port #(.STEP_CYC(STEP), .SAMPLE_CYC(SMP)) i_dut (.clk, .rst,
      .s_axi_awaddr(awa), .s_axi_awvalid(awv), .s_axi_awready(awr),
      .s_axi_wdata(wd), .s_axi_wstrb(ws), .s_axi_wvalid(wv),
      .s_axi_wready(wrd), .s_axi_bresp(bresp), .s_axi_bvalid(bv),
      .s_axi_bready(br), .s_axi_araddr(ara), .s_axi_arvalid(arv),
      .s_axi_arready(arr), .s_axi_rdata(rd_d), .s_axi_rresp(rresp),
      .s_axi_rvalid(rv), .s_axi_rready(rr), .pad_in(pin), .dflt_out(dout),
      .dflt_oe(doe), .pad_out(po), .pad_oe(poe), .pad_pu(ppu),
      .pad_pd(ppd), .pad_slow(psl), .led_on(led));
   pgp_pad_model i_pad (.clk, .pad_out(po), .pad_oe(poe), .pad_pu(ppu),
      .pad_pd(ppd), .ext_en(5'h1f), .ext_val(ext_val), .pad_in(pin));

   always #2 clk = ~clk;

   task automatic summarize;
      $display("checks %0d mismatches %0d", check_count, fail_count);
      if (fail_count == 0 && check_count > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask

   task automatic chk(input logic [31:0] s, input logic [31:0] e);
      check_count++;
      if (s !== e) begin
         fail_count++;
         $display("[ERR] %0t seen %h expected %h", $time, s, e);
      end
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] v);
      int k;
      logic pa, pw;
      @(posedge clk);
      awa <= a;
      wd <= v;
      awv <= 1'b1;
      wv <= 1'b1;
      br <= 1'b1;
      pa = 1'b1;
      pw = 1'b1;
      for (k = 0; k < 200; k++) begin
         @(posedge clk);
         if (pa && awr) begin
            pa = 1'b0;
            awv <= 1'b0;
         end
         if (pw && wrd) begin
            pw = 1'b0;
            wv <= 1'b0;
         end
         if (bv) break;
      end
      if (k == 200) fail_count++;
      rsp = bresp;
      br <= 1'b0;
   endtask

   task automatic rd(input logic [7:0] a, output logic [31:0] v);
      int k;
      @(posedge clk);
      ara <= a;
      arv <= 1'b1;
      rr <= 1'b1;
      for (k = 0; k < 200; k++) begin
         @(posedge clk);
         if (arv && arr) arv <= 1'b0;
         if (rv) break;
      end
      if (k == 200) fail_count++;
      v = rd_d;
      rsp = rresp;
      rr <= 1'b0;
   endtask

   task automatic cmd(input logic [7:0] x, v, c, t, input logic [1:0] l);
      wr(pgp_pkg::ADDR_REQ_DATA, {8'h00, c, v, x});
      wr(pgp_pkg::ADDR_REQ_CTRL, {22'h0, l, t});
      rd(pgp_pkg::ADDR_RSP_HDR, hdr);
      rd(pgp_pkg::ADDR_RSP_DATA, dat);
   endtask

   task automatic set(input logic [7:0] x, v, c, input logic [1:0] l);
      cmd(x, v, c, pgp_pkg::TYPE_SET, l);
      chk(hdr, {24'h0, pgp_pkg::RSP_SET});
   endtask

   task automatic get(input logic [7:0] x);
      cmd(x, 8'h00, 8'h00, pgp_pkg::TYPE_GET, pgp_pkg::LEN_GET);
      chk(hdr, {21'h0, pgp_pkg::RLEN_GET, pgp_pkg::RSP_GET});
   endtask

   task automatic bad(input logic [7:0] x, t, input logic [1:0] l);
      cmd(x, 8'd50, 8'h09, t, l);
      chk(hdr, 32'h1 << pgp_pkg::RSP_ERR_BIT);
   endtask

   // Bits: driven level, drive enable, pull up, pull down, slow edge.
   function automatic logic [4:0] drv(logic [2:0] m, logic h);
      case (m)
         3'h0: drv = h ? 5'b11000 : 5'b00010;
         3'h1: drv = h ? 5'b11000 : 5'b01000;
         3'h3: drv = h ? 5'b00100 : 5'b01000;
         3'h4: drv = h ? 5'b11001 : 5'b00000;
         3'h5: drv = h ? 5'b11001 : 5'b01001;
         3'h7: drv = h ? 5'b00000 : 5'b01001;
         default: drv = 5'b00000;
      endcase
   endfunction

   initial begin
      repeat (30000) @(posedge clk);
      fail_count++;
      summarize();
   end

   initial begin
      clk = 1'b0;
      rst = 1'b1;
      {awv, wv, br, arv, rr} = 5'h00;
      {awa, ara, wd, ws} = {16'h0, 32'h0, 4'hf};
      {dout, doe, ext_val} = 15'h0;
      void'($urandom(32'h2afd));
      repeat (12) @(posedge clk);
      rst <= 1'b0;
      for (i = 0; i < 13; i++) begin
         get(i[7:0]);
         chk(dat, {24'h0, i[7:0]});
      end
      $display("reset state test done");
      for (int m = 0; m < 8; m++) begin
         if (m == 6) continue;
         i = $urandom_range(4, 0);
         for (int h = 0; h < 2; h++) begin
            set(i[7:0], h ? 8'd100 : 8'd0, {5'h01, m[2:0]}, pgp_pkg::LEN_CFG);
            repeat (2) @(posedge clk);
            chk({po[i] & poe[i], poe[i], ppu[i], ppd[i], psl[i] & poe[i]},
               {27'h0, drv(m[2:0], h[0])});
         end
         get(i[7:0]);
         chk(dat[31:16], {5'h01, m[2:0], 8'd100});
      end
      set(i[7:0], 8'd37, 8'h02, pgp_pkg::LEN_VAL);
      get(i[7:0]);
      chk(dat[31:16], {8'h0f, 8'd37});
      $display("drive mode test done");
      bad(8'd13, pgp_pkg::TYPE_SET, pgp_pkg::LEN_CFG);
      bad(8'd255, pgp_pkg::TYPE_GET, pgp_pkg::LEN_GET);
      bad(8'd0, 8'h21, pgp_pkg::LEN_GET);
      bad(8'd0, pgp_pkg::TYPE_SET, pgp_pkg::LEN_GET);
      get(8'd12);
      chk(dat, 32'h0000_000c);
      wr(8'h14, 32'h1);
      chk({30'h0, rsp}, {30'h0, pgp_pkg::RESP_DECERR});
      rd(8'h14, dat);
      chk(dat, 32'h0);
      chk({30'h0, rsp}, {30'h0, pgp_pkg::RESP_DECERR});
      $display("refusal test done");
      set(8'd0, 8'd100, 8'h0a, pgp_pkg::LEN_CFG);
      repeat (4 * SMP) @(posedge clk);
      get(8'd0);
      ext_val[0] <= 1'b1;
      repeat (4 * SMP) @(posedge clk);
      get(8'd0);
      chk(dat[15:8], 8'h05);
      get(8'd0);
      chk(dat[15:8], 8'h01);
      ext_val[0] <= 1'b0;
      repeat (SMP - 4) @(posedge clk);
      ext_val[0] <= 1'b1;
      repeat (4 * SMP) @(posedge clk);
      get(8'd0);
      chk(dat[15:8], 8'h01);
      ext_val[0] <= 1'b0;
      repeat (4 * SMP) @(posedge clk);
      get(8'd0);
      chk(dat[23:8], {8'd100, 8'h02});
      set(8'd5, 8'd100, 8'h09, pgp_pkg::LEN_CFG);
      repeat (4 * SMP) @(posedge clk);
      get(8'd5);
      chk(dat[15:8], 8'h05);
      $display("sampling test done");
      for (int k = 0; k < 3; k++) begin
         d = k == 0 ? 0 : k == 1 ? 100 : $urandom_range(99, 1);
         set(8'd6, d[7:0], 8'h09, pgp_pkg::LEN_CFG);
         repeat (100 * STEP + 2) @(posedge clk);
         n = 0;
         repeat (100 * STEP) begin
            @(negedge clk);
            n += led[1];
         end
         chk(n, d * STEP);
      end
      set(8'd6, 8'd100, 8'h01, pgp_pkg::LEN_CFG);
      set(8'd7, 8'd100, 8'h0a, pgp_pkg::LEN_CFG);
      chk(led[2:1], 2'b00);
      dout <= 5'($urandom);
      doe <= 5'($urandom);
      set(8'd1, 8'd100, 8'h01, pgp_pkg::LEN_CFG);
      repeat (2) @(posedge clk);
      chk({po[1], poe[1], ppu[1], ppd[1]}, {dout[1], doe[1], 2'b00});
      $display("output test done");
      set(8'd3, 8'd50, 8'h0d, pgp_pkg::LEN_CFG);
      wr(pgp_pkg::ADDR_BOOT, 32'h1 << pgp_pkg::BOOT_STORE);
      set(8'd3, 8'd7, 8'h02, pgp_pkg::LEN_CFG);
      wr(pgp_pkg::ADDR_BOOT, 32'h1 << pgp_pkg::BOOT_LOAD);
      get(8'd3);
      chk(dat[31:16], {8'h0d, 8'd50});
      $display("boot state test done");
      summarize();
   end
endmodule
